// ---- design/fsr_regs.vh ----
// Constants shared by the soft-reset and parameter-table command slice
// Function
// - Enable-reset frame, then separate reset frame
// - Accepted reset aborts work, returns to default
// - Reset clears every volatile status field; a volLoad in the same cycle wins
// - Reset takes 60us, commands ignored meanwhile
// - Parameter-read opcode returns table bytes
// - Revision and header count bytes fixed
// - Unused header bytes always read FFH
// - First header: id 00H, rev 1.0, 9 dwords
// - Standard table pointer is 000030H
// - Second header: rev 1.0, 3 dwords, 60H
// - Table byte 30H reads E5H
// - Table byte 31H reads 4 KB erase opcode
// - Byte 32H reads F1H, 33H FFH
// - 1-4-4 read: 4 wait, 2 mode, EBH
// - 1-1-4 read: 8 wait, no mode, 6BH
// - Table advertises soft reset needing enable first
`ifndef FSR_REGS_VH
`define FSR_REGS_VH

// Opcodes
`define FSR_OP_RST_EN   8'h66
`define FSR_OP_RST      8'h99
`define FSR_OP_PARAM_RD 8'h5a

// Frame field lengths in serial clocks
`define FSR_OPC_BITS   4'h8
`define FSR_ADDR_BITS  5'h18
`define FSR_DUMMY_BITS 4'h8

// Reset recovery time
`define FSR_TRST_NS  60000
`define FSR_CLK_NS   100
`define FSR_TRST_CYC ((`FSR_TRST_NS) / (`FSR_CLK_NS))

// Reset values of volatile state
`define FSR_WEL_RST   1'b0
`define FSR_SUS_RST   1'b0
`define FSR_PARAM_RST 8'h00
`define FSR_MODE_RST  8'h00
`define FSR_WRAP_RST  3'h0

// Table: identifier of second header (arbitrary value)
`define FSR_VND_ID    8'h5a
// Value read at unpopulated table offsets
`define FSR_FILL      8'hff

`endif

// ---- design/fsr_table.v ----
// Read-only discoverable-parameter table lookup
`timescale 1ns/1ps
`include "fsr_regs.vh"
module fsr_table (
  input  wire [23:0] addr,   // Byte offset into the table
  output reg  [7:0]  data    // Byte at that offset
);
  // Byte lookup; everything not listed reads the fill value
  always @* begin
    data = `FSR_FILL;
    if (addr[23:8] == 16'h0000) begin
      case (addr[7:0])
        8'h00:   data = 8'h53;
        8'h01:   data = 8'h46;
        8'h02:   data = 8'h44;
        8'h03:   data = 8'h50;
        8'h04:   data = 8'h00;
        8'h05:   data = 8'h01;
        8'h06:   data = 8'h01;
        8'h07:   data = 8'hff;
        8'h08:   data = 8'h00;
        8'h09:   data = 8'h00;
        8'h0a:   data = 8'h01;
        8'h0b:   data = 8'h09;
        8'h0c:   data = 8'h30;
        8'h0d:   data = 8'h00;
        8'h0e:   data = 8'h00;
        8'h0f:   data = 8'hff;
        8'h10:   data = `FSR_VND_ID;
        8'h11:   data = 8'h00;
        8'h12:   data = 8'h01;
        8'h13:   data = 8'h03;
        8'h14:   data = 8'h60;
        8'h15:   data = 8'h00;
        8'h16:   data = 8'h00;
        8'h17:   data = 8'hff;
        8'h30:   data = 8'he5;
        8'h31:   data = 8'h20;
        8'h32:   data = 8'hf1;
        8'h33:   data = 8'hff;
        8'h34:   data = 8'hff; // Density low byte
        8'h35:   data = 8'hff; // Density
        8'h36:   data = 8'h7f; // Density
        8'h37:   data = 8'h00; // Density high byte
        8'h38:   data = 8'h44;
        8'h39:   data = 8'heb;
        8'h3a:   data = 8'h08;
        8'h3b:   data = 8'h6b;
        8'h64:   data = 8'h9e;
        8'h65:   data = 8'hf9;
        default: data = `FSR_FILL;
      endcase
    end
  end
endmodule

// ---- design/fsr_top.v ----
// Soft-reset sequencer and parameter-read responder of the serial flash
`timescale 1ns/1ps
`include "fsr_regs.vh"
module fsr_top (
  input  wire       clk,          // Device clock, 10 MHz
  input  wire       arst_n,       // Asynchronous reset, active low
  input  wire       csN,          // Chip select pin, active low
  input  wire       sclk,         // Serial clock pin
  input  wire       mosi,         // Serial data in pin
  output reg        miso,         // Serial data out pin
  output reg        misoOe,       // Serial data out enable
  input  wire       volLoad,      // Load strobe for volatile fields
  input  wire       volWelIn,     // New write enable latch value
  input  wire       volSusIn,     // New suspend flag value
  input  wire [7:0] volParamIn,   // New read parameter field
  input  wire [7:0] volModeIn,    // New continuous read byte
  input  wire [2:0] volWrapIn,    // New wrap setting field
  output reg        writeEnableLatch,   // Volatile write enable
  output reg        suspendFlag,        // Volatile suspend state
  output reg  [7:0] readParamField,     // Volatile read parameters
  output reg  [7:0] continuousReadByte, // Volatile mode byte
  output reg  [2:0] wrapSettingField,   // Volatile wrap setting
  output reg        resetEnabled, // Reset enable pending
  output reg        resetBusy,    // Reset recovery in progress
  output reg        abortOp       // One-cycle abort of internal work
);
  // Frame states, one-hot
  localparam [4:0] ST_OPC   = 5'b0_0001;
  localparam [4:0] ST_ADDR  = 5'b0_0010;
  localparam [4:0] ST_DUMMY = 5'b0_0100;
  localparam [4:0] ST_DATA  = 5'b0_1000;
  localparam [4:0] ST_SKIP  = 5'b1_0000;
  localparam integer RST_CYC_I = `FSR_TRST_CYC;  // Recovery length
  localparam [9:0]   RST_CYC   = RST_CYC_I[9:0]; // Counter load value

  // Pin synchronisers
  reg        csS1_q;       // Chip select, first stage
  reg        csS2_q;       // Chip select, second stage
  reg        csS3_q;       // Chip select, edge history
  reg        sclkS1_q;     // Serial clock, first stage
  reg        sclkS2_q;     // Serial clock, second stage
  reg        sclkS3_q;     // Serial clock, edge history
  reg        mosiS1_q;     // Data in, first stage
  reg        mosiS2_q;     // Data in, second stage
  // Frame decode
  reg  [4:0] state_q;      // Frame state
  reg  [4:0] bitCnt_q;     // Bits within current field
  reg  [7:0] opcShift_q;   // Opcode shift register
  reg  [7:0] opcode_q;     // Completed opcode
  reg        opcValid_q;   // A full opcode arrived
  reg        extra_q;      // Clocks seen past the opcode
  reg [23:0] rdAddr_q;     // Table address, auto-increment
  // Output shifter
  reg  [7:0] outSh_q;      // Byte being shifted out
  reg  [2:0] outCnt_q;     // Bit position within byte
  // Reset recovery
  reg  [9:0] rstCnt_q;     // Cycles left in recovery
  // Two-entry buffer
  reg  [7:0] bufMem_q [0:1]; // Buffer storage
  reg        bufWr_q;      // Write index
  reg        bufRd_q;      // Read index
  reg  [1:0] bufCnt_q;     // Occupancy

  wire       csFall;       // Frame start
  wire       csRise;       // Frame end
  wire       sclkRise;     // Sampling edge
  wire       sclkFall;     // Shifting edge
  wire       inFrame;      // Chip select held low
  wire       singleOp;     // Frame was exactly one opcode
  wire       fireRst;      // Reset accepted this cycle
  wire [7:0] romData;      // Table byte at read address
  wire       bufInValid;   // Producer offers a byte
  wire       bufInReady;   // Buffer has room
  wire       bufOutValid;  // Buffer holds a byte
  wire       bufOutReady;  // Shifter takes a byte
  wire       bufPush;      // Byte written
  wire       bufPop;       // Byte read
  wire [7:0] bufHead;      // Oldest byte
  wire [1:0] bufCntInc;    // Occupancy plus one
  wire [1:0] bufCntDec;    // Occupancy minus one
  wire [7:0] nextByte;     // Byte handed to shifter

  // Edge detection uses only settled stages
  assign csFall   = csS3_q & ~csS2_q;
  assign csRise   = ~csS3_q & csS2_q;
  assign sclkRise = ~sclkS3_q & sclkS2_q;
  assign sclkFall = sclkS3_q & ~sclkS2_q;
  assign inFrame  = ~csS2_q & ~csS3_q;

  // One opcode alone in its frame counts as a reset step
  assign singleOp = opcValid_q & ~extra_q;
  assign fireRst  = csRise & ~resetBusy & singleOp &
                    (opcode_q == `FSR_OP_RST) & resetEnabled;

  // Synchronise all pins into the device clock
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Idle levels: deselected, clock low
      csS1_q   <= 1'b1;
      csS2_q   <= 1'b1;
      csS3_q   <= 1'b1;
      sclkS1_q <= 1'b0;
      sclkS2_q <= 1'b0;
      sclkS3_q <= 1'b0;
      mosiS1_q <= 1'b0;
      mosiS2_q <= 1'b0;
    end else begin
      // Two stages per pin, a third for edges
      csS1_q   <= csN;
      csS2_q   <= csS1_q;
      csS3_q   <= csS2_q;
      sclkS1_q <= sclk;
      sclkS2_q <= sclkS1_q;
      sclkS3_q <= sclkS2_q;
      mosiS1_q <= mosi;
      mosiS2_q <= mosiS1_q;
    end
  end

  // Frame state machine: opcode, address, dummy, data
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_OPC;
      bitCnt_q   <= 5'h00;
      opcShift_q <= 8'h00;
      opcode_q   <= 8'h00;
      opcValid_q <= 1'b0;
      extra_q    <= 1'b0;
    end else if (csFall) begin
      // New frame; during recovery the frame is dropped
      bitCnt_q   <= 5'h00;
      opcValid_q <= 1'b0;
      extra_q    <= 1'b0;
      state_q    <= resetBusy ? ST_SKIP : ST_OPC;
    end else if (csRise) begin
      // Frame over, wait for the next one
      state_q    <= ST_OPC;
      bitCnt_q   <= 5'h00;
    end else if (inFrame && sclkRise) begin
      case (state_q)
        ST_OPC: begin
          // Opcode bits, most significant first
          opcShift_q <= {opcShift_q[6:0], mosiS2_q};
          bitCnt_q   <= bitCnt_q + 5'h01;
          if (bitCnt_q == {1'b0, `FSR_OPC_BITS} - 5'h01) begin
            opcode_q   <= {opcShift_q[6:0], mosiS2_q};
            opcValid_q <= 1'b1;
            bitCnt_q   <= 5'h00;
            // Parameter read continues with an address
            if ({opcShift_q[6:0], mosiS2_q} == `FSR_OP_PARAM_RD) begin
              state_q <= ST_ADDR;
            end else begin
              state_q <= ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          // Address bits land in the table address
          bitCnt_q <= bitCnt_q + 5'h01;
          if (bitCnt_q == `FSR_ADDR_BITS - 5'h01) begin
            bitCnt_q <= 5'h00;
            state_q  <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // Dummy clocks, nothing sampled
          bitCnt_q <= bitCnt_q + 5'h01;
          if (bitCnt_q == {1'b0, `FSR_DUMMY_BITS} - 5'h01) begin
            bitCnt_q <= 5'h00;
            state_q  <= ST_DATA;
          end
        end
        ST_DATA: begin
          // Bytes streaming; frame counts as long
          extra_q <= 1'b1;
        end
        ST_SKIP: begin
          // Any clock past the opcode marks a longer frame
          extra_q <= 1'b1;
        end
        default: begin
          // Illegal code, resynchronise
          state_q <= ST_OPC;
        end
      endcase
    end
  end

  // Reset enable latch; any other full command drops it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resetEnabled <= 1'b0;
    end else if (csRise && !resetBusy && opcValid_q) begin
      if (singleOp && opcode_q == `FSR_OP_RST_EN) begin
        resetEnabled <= 1'b1;
      end else begin
        resetEnabled <= 1'b0;
      end
    end
  end

  // Recovery timer and abort pulse after an accepted reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstCnt_q  <= 10'h000;
      resetBusy <= 1'b0;
      abortOp   <= 1'b0;
    end else begin
      abortOp <= fireRst;
      if (fireRst) begin
        rstCnt_q  <= RST_CYC;
        resetBusy <= 1'b1;
      end else if (resetBusy) begin
        // Count down; busy ends with the last cycle
        rstCnt_q <= rstCnt_q - 10'h001;
        if (rstCnt_q == 10'h001) begin
          resetBusy <= 1'b0;
        end
      end
    end
  end

  // Volatile state; a load in the reset cycle wins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      writeEnableLatch   <= `FSR_WEL_RST;
      suspendFlag        <= `FSR_SUS_RST;
      readParamField     <= `FSR_PARAM_RST;
      continuousReadByte <= `FSR_MODE_RST;
      wrapSettingField   <= `FSR_WRAP_RST;
    end else if (volLoad) begin
      writeEnableLatch   <= volWelIn;
      suspendFlag        <= volSusIn;
      readParamField     <= volParamIn;
      continuousReadByte <= volModeIn;
      wrapSettingField   <= volWrapIn;
    end else if (fireRst) begin
      writeEnableLatch   <= `FSR_WEL_RST;
      suspendFlag        <= `FSR_SUS_RST;
      readParamField     <= `FSR_PARAM_RST;
      continuousReadByte <= `FSR_MODE_RST;
      wrapSettingField   <= `FSR_WRAP_RST;
    end
  end

  // Table address: shifted in, then stepped per fetched byte
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdAddr_q <= 24'h00_0000;
    end else if (inFrame && sclkRise && state_q == ST_ADDR) begin
      rdAddr_q <= {rdAddr_q[22:0], mosiS2_q};
    end else if (bufPush) begin
      // One step per byte taken by the buffer
      rdAddr_q <= rdAddr_q + 24'h00_0001;
    end
  end

  // Table lookup
  fsr_table u_table (
    .addr (rdAddr_q),
    .data (romData)
  );

  // Producer fills the buffer only while data is streaming
  assign bufInValid  = inFrame & (state_q == ST_DATA);
  assign bufInReady  = (bufCnt_q != 2'h2);
  assign bufPush     = bufInValid & bufInReady;
  assign bufOutValid = (bufCnt_q != 2'h0);
  assign bufOutReady = inFrame & sclkFall & (state_q == ST_DATA) &
                       (outCnt_q == 3'h0);
  assign bufPop      = bufOutValid & bufOutReady;
  assign bufHead     = bufMem_q[bufRd_q];
  assign bufCntInc   = bufCnt_q + 2'h1;
  assign bufCntDec   = bufCnt_q - 2'h1;
  assign nextByte    = bufOutValid ? bufHead : `FSR_FILL;

  // Buffer entries, one writer each
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_buf
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          bufMem_q[gi] <= 8'h00;
        end else if (bufPush && (bufWr_q == (gi == 1))) begin
          // Entry picked by the write index
          bufMem_q[gi] <= romData;
        end
      end
    end
  endgenerate

  // Buffer indices; emptied at every frame end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bufWr_q  <= 1'b0;
      bufRd_q  <= 1'b0;
      bufCnt_q <= 2'h0;
    end else if (!inFrame) begin
      // Deselected: drop any prefetched bytes
      bufWr_q  <= 1'b0;
      bufRd_q  <= 1'b0;
      bufCnt_q <= 2'h0;
    end else begin
      if (bufPush) begin
        bufWr_q <= ~bufWr_q;
      end
      if (bufPop) begin
        bufRd_q <= ~bufRd_q;
      end
      if (bufPush && !bufPop) begin
        bufCnt_q <= bufCntInc;
      end else if (bufPop && !bufPush) begin
        bufCnt_q <= bufCntDec;
      end
    end
  end

  // Output shifter, most significant bit first on falling edge
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outSh_q  <= 8'h00;
      outCnt_q <= 3'h0;
      miso     <= 1'b0;
      misoOe   <= 1'b0;
    end else if (!inFrame || state_q != ST_DATA) begin
      // Not streaming: release the data line
      outCnt_q <= 3'h0;
      misoOe   <= 1'b0;
      miso     <= 1'b0;
    end else if (sclkFall) begin
      misoOe   <= 1'b1;
      outCnt_q <= outCnt_q + 3'h1;
      if (outCnt_q == 3'h0) begin
        // Start of byte: take the next table byte
        outSh_q <= {nextByte[6:0], 1'b1};
        miso    <= nextByte[7];
      end else begin
        // Later bits: shift the held byte
        outSh_q <= {outSh_q[6:0], 1'b1};
        miso    <= outSh_q[7];
      end
    end
  end
endmodule

// ---- dv/fsr_properties.sv ----
// Concurrent checks on the soft-reset and table-read slice
`timescale 1ns/1ps
`include "fsr_regs.vh"
module fsr_checker (
  input logic       clk,                // Device clock
  input logic       arst_n,             // Async reset, active low
  input logic       csN,                // Chip select pin
  input logic       misoOe,             // Data out enable
  input logic       volLoad,            // Volatile load strobe
  input logic       writeEnableLatch,   // Volatile write enable
  input logic       suspendFlag,        // Volatile suspend
  input logic [7:0] readParamField,     // Volatile parameters
  input logic [7:0] continuousReadByte, // Volatile mode byte
  input logic [2:0] wrapSettingField,   // Volatile wrap
  input logic       resetEnabled,       // Reset enable pending
  input logic       resetBusy,          // Recovery running
  input logic       abortOp             // Abort pulse
);
  int unsigned busyCnt_q;  // Cycles spent in recovery
  logic [20:0] volNow;     // All volatile fields together
  assign volNow = {writeEnableLatch, suspendFlag, readParamField,
                   continuousReadByte, wrapSettingField};
  // Count recovery cycles, restart when idle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      busyCnt_q <= 0;
    else
      busyCnt_q <= resetBusy ? busyCnt_q + 1 : 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_abort_one_cycle: assert property (abortOp |=> !abortOp)
    else $error("abort pulse longer than one cycle");
  a_abort_with_busy: assert property (abortOp |-> $rose(resetBusy))
    else $error("abort without start of recovery");
  a_busy_needs_abort: assert property ($rose(resetBusy) |-> abortOp)
    else $error("recovery without abort pulse");
  a_reset_clears_vol: assert property (
    abortOp && !$past(volLoad) |-> volNow == '0)
    else $error("volatile state kept over reset");
  a_enable_consumed: assert property (abortOp |-> !resetEnabled)
    else $error("reset enable still pending after reset");
  a_accept_needs_enable: assert property (
    $rose(resetBusy) |-> $past(resetEnabled))
    else $error("reset accepted without prior enable");
  a_busy_length: assert property (
    $fell(resetBusy) |-> busyCnt_q == `FSR_TRST_CYC)
    else $error("recovery time wrong");
  a_busy_no_enable: assert property (
    resetBusy |-> !$rose(resetEnabled))
    else $error("command taken during recovery");
  a_busy_no_output: assert property (resetBusy |-> !misoOe)
    else $error("data driven during recovery");
  a_oe_needs_select: assert property (csN [*8] |=> !misoOe)
    else $error("data driven while deselected");
  c_reset_taken: cover property ($rose(resetBusy));
  c_reset_done: cover property ($fell(resetBusy));
  c_read_data: cover property ($rose(misoOe));
endmodule

bind fsr_top fsr_checker i_fsr_checker (.clk, .arst_n, .csN, .misoOe,
  .volLoad, .writeEnableLatch, .suspendFlag, .readParamField,
  .continuousReadByte, .wrapSettingField, .resetEnabled, .resetBusy,
  .abortOp);

// ---- dv/fsr_host_model.sv ----
// Behavioural SPI host that frames commands for the flash slice
`timescale 1ns/1ps
module fsr_host_model (
  output logic csN,  // Chip select, active low
  output logic sclk, // Serial clock, idle low
  output logic mosi, // Serial data to device
  input  logic miso  // Serial data from device
);
  int          half = 400; // Half link period in ns, raised to stall
  logic [31:0] rx;         // Last bits read back
  // Idle bus at time zero
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // One frame: nTx bits MSB first, then nRx clocks read back
  task automatic frame(input logic [31:0] hdr, input int nTx,
                       input int nRx);
    csN = 1'b0;
    #half;
    for (int i = 0; i < nTx + nRx; i++) begin
      mosi = (i < nTx) ? hdr[31-i] : ~mosi;
      #half sclk = 1'b1;
      #half rx = {rx[30:0], miso};
      sclk = 1'b0;
    end
    #half csN = 1'b1;
    mosi = ~mosi; // Released line shows no stale value
    #800;
  endtask
endmodule

// ---- dv/tb_flash_soft_reset_and_sfdp.sv ----
// Self-checking bench for the soft-reset and table-read slice
`timescale 1ns/1ps
`include "fsr_regs.vh"
module tb_flash_soft_reset_and_sfdp;
  typedef struct {logic [23:0] addr; logic [31:0] exp;} fsr_row_t;
  logic        clk;        // Device clock
  logic        arst_n;     // Async reset
  logic        csN, sclk, mosi, miso, misoOe; // Link pins
  logic        volLoad, volWelIn, volSusIn;  // Volatile load
  logic [7:0]  volParamIn, volModeIn;        // Volatile load bytes
  logic [2:0]  volWrapIn;                    // Volatile load wrap
  logic        writeEnableLatch, suspendFlag; // Volatile outputs
  logic [7:0]  readParamField, continuousReadByte;
  logic [2:0]  wrapSettingField;
  logic        resetEnabled, resetBusy, abortOp; // Reset status
  logic [20:0] volNow;     // Volatile outputs together
  int miscompares = 0, checkCount = 0; // Verdict counters
  int aborts = 0, busyCyc = 0, oeCyc = 0; // Event counters
  int          oeBase = 0; // Enable count before a step
  logic [25:0] allOut;     // Every status output and the data line
  localparam logic [20:0] VOLV = {2'b11, 8'ha5, 8'h3c, 3'h5};
  // Table rows: start offset and four streamed bytes
  fsr_row_t rows [10] = '{
    '{24'h00_0000, 32'h5346_4450},
    '{24'h00_0004, 32'h0001_01ff},
    '{24'h00_0008, 32'h0000_0109},
    '{24'h00_000c, 32'h3000_00ff},
    '{24'h00_0010, {`FSR_VND_ID, 24'h00_0103}},
    '{24'h00_0014, 32'h6000_00ff},
    '{24'h00_0030, 32'he520_f1ff},
    '{24'h00_0038, 32'h44eb_086b},
    '{24'h00_0064, 32'h9ef9_ffff},
    '{24'h00_00fe, 32'hffff_ffff}};
  assign volNow = {writeEnableLatch, suspendFlag, readParamField,
                   continuousReadByte, wrapSettingField};
  assign allOut = {volNow, resetEnabled, resetBusy, abortOp, misoOe, miso};

  fsr_top i_fsr_top (.clk, .arst_n, .csN, .sclk, .mosi, .miso, .misoOe,
    .volLoad, .volWelIn, .volSusIn, .volParamIn, .volModeIn, .volWrapIn,
    .writeEnableLatch, .suspendFlag, .readParamField, .continuousReadByte,
    .wrapSettingField, .resetEnabled, .resetBusy, .abortOp);
  fsr_host_model i_fsr_host_model (.csN, .sclk, .mosi, .miso);

  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Event counters sampled on the device clock
  always @(posedge clk) begin
    if (abortOp === 1'b1) aborts++;
    if (resetBusy === 1'b1) busyCyc++;
    if (misoOe === 1'b1) oeCyc++;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic final_report();
    if (miscompares == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Command-only frame with n clocks
  task automatic cmd(input logic [7:0] op, input int n);
    @(posedge clk) #10;
    i_fsr_host_model.frame({op, 24'h0}, n, 0);
  endtask
  // Four-byte table read
  task automatic rd(input logic [23:0] a);
    @(posedge clk) #10;
    i_fsr_host_model.frame({8'h5a, a}, 32, 40);
  endtask
  // Strobe new volatile values for one cycle
  task automatic load(input logic [20:0] v);
    @(posedge clk) #10;
    {volWelIn, volSusIn, volParamIn, volModeIn, volWrapIn} = v;
    volLoad = 1'b1;
    @(posedge clk) #10;
    volLoad = 1'b0;
  endtask
  // Bounded wait for recovery to end
  task automatic wait_idle();
    int n;
    n = 0;
    while (resetBusy !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 700) begin
        miscompares++;
        final_report();
      end
    end
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    volLoad = 1'b0;
    {volWelIn, volSusIn, volParamIn, volModeIn, volWrapIn} = '0;
    repeat (2) @(posedge clk);
    #10 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    #10;
    check(32'(allOut), 32'h0);
    // Table rows, last one with a stalling host
    for (int i = 0; i < 10; i++) begin
      if (i == 9) i_fsr_host_model.half = 700;
      rd(rows[i].addr);
      check(i_fsr_host_model.rx, rows[i].exp);
    end
    i_fsr_host_model.half = 400;
    // Accepted reset clears volatile state and aborts
    load(VOLV);
    check(32'(volNow), 32'(VOLV));
    wait_idle();
    cmd(8'h66, 8);
    check(32'(resetEnabled), 32'h1);
    cmd(8'h99, 8);
    check(32'(aborts), 32'h1);
    check(32'(volNow), 32'h0);
    check(32'({resetBusy, resetEnabled}), 32'h2);
    // Commands during recovery are ignored
    oeBase = oeCyc;
    cmd(8'h66, 8);
    check(32'(resetEnabled), 32'h0);
    rd(24'h0);
    check(32'(oeCyc - oeBase), 32'h0);
    wait_idle();
    check(32'(busyCyc), `FSR_TRST_CYC);
    // Lone reset opcode is not accepted
    load(VOLV);
    cmd(8'h99, 8);
    check(32'({aborts, volNow}), 32'({1'b1, VOLV}));
    // Other opcode between enable and reset drops the enable
    cmd(8'h66, 8);
    cmd(8'h03, 8);
    check(32'(resetEnabled), 32'h0);
    cmd(8'h99, 8);
    check(32'(aborts), 32'h1);
    // Short frame is ignored, over-long reset frame is refused
    cmd(8'h66, 8);
    cmd(8'h99, 4);
    check(32'(resetEnabled), 32'h1);
    cmd(8'h99, 9);
    check(32'({aborts, resetEnabled}), 32'h2);
    // Asynchronous reset in mid-run drops a pending enable
    cmd(8'h66, 8);
    check(32'(resetEnabled), 32'h1);
    @(posedge clk) #10 arst_n = 1'b0;
    @(posedge clk) #10 arst_n = 1'b1;
    check(32'({resetEnabled, volNow}), 32'h0);
    repeat (2) @(posedge clk);
    #10;
    check(32'(allOut), 32'h0);
    rd(rows[0].addr);
    check(i_fsr_host_model.rx, rows[0].exp);
    final_report();
  end
endmodule
